// >>> shared/pbslc_pkg.sv
// Package for the signaling registers and link counters: map, layouts, carriers
package pbslc_pkg;
    // Register indices on the processor port
    localparam logic [4:0] PBSLC_OFS_TX = 5'h03;
    localparam logic [4:0] PBSLC_OFS_LEN = 5'h04;
    localparam logic [4:0] PBSLC_OFS_LIM = 5'h05;
    localparam logic [4:0] PBSLC_OFS_RX = 5'h16;
    localparam logic [4:0] PBSLC_OFS_EVT = 5'h17;
    localparam logic [4:0] PBSLC_OFS_BAD = 5'h18;
    localparam logic [4:0] PBSLC_OFS_IDLE = 5'h19;
    localparam logic [4:0] PBSLC_OFS_LEC = 5'h1A;
    localparam logic [4:0] PBSLC_OFS_MASK = 5'h1C;
    localparam logic [4:0] PBSLC_OFS_CTLA = 5'h1D;
    // Event register bit positions
    localparam int PBSLC_EV_INVALID = 15;
    localparam int PBSLC_EV_LINK = 13;
    localparam int PBSLC_EV_IDLE = 12;
    localparam int PBSLC_EV_BAD = 11;
    // Control register a: 1 selects count event on overflow only; an idle minimum drop still raises its event
    localparam int PBSLC_CTL_BAD_SEL = 0;
    localparam int PBSLC_CTL_IDLE_SEL = 1;
    // Values after reset or clear, and the occurrence count saturation value
    localparam logic [15:0] PBSLC_RST_16 = 16'h0000;
    localparam logic [2:0] PBSLC_IDLE_MIN_RST = 3'h7;
    localparam logic [3:0] PBSLC_OCC_RST = 4'h0;
    localparam logic [3:0] PBSLC_OCC_MAX = 4'hF;
    // Idle pair minimum, binary count to field code
    localparam logic [2:0] PBSLC_MIN_CODE [8] = '{3'h0, 3'h1, 3'h3, 3'h2,
                                                  3'h6, 3'h7, 3'h5, 3'h4};
    // Occurrence count (index = count - 1) to field code
    localparam logic [3:0] PBSLC_OCC_CODE [16] = '{4'h0, 4'h8, 4'hC, 4'h4,
                                                   4'h5, 4'h7, 4'hF, 4'hE,
                                                   4'hA, 4'h2, 4'h3, 4'h1,
                                                   4'h9, 4'hD, 4'h6, 4'hB};

    typedef enum logic [1:0] {
        PBSLC_SIG_IDLE = 2'b01,
        PBSLC_SIG_SEND = 2'b10
    } pbslc_sig_t;

    // Processor request
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pbslc_bus_t;

    // Line side inputs
    typedef struct packed {
        logic bit_tick;
        logic rx_halt;
        logic viol;
        logic gap_seen;
        logic [2:0] gap_pairs;
        logic link_err;
    } pbslc_line_t;

    // Whole state of the block
    typedef struct packed {
        pbslc_sig_t st;
        logic [15:0] tx;
        logic [3:0] len;
        logic [3:0] idx;
        logic [15:0] rx;
        logic [7:0] lim;
        logic [7:0] bad;
        logic [2:0] imin;
        logic [3:0] iocc;
        logic [7:0] lec;
        logic [15:0] ev;
        logic [15:0] mask;
        logic [1:0] ctl;
        logic [15:0] rdata;
        logic irq;
        logic tx_halt;
        logic tx_master;
    } pbslc_state_t;
endpackage : pbslc_pkg

// >>> hdl/pbslc_core.sv
// Bit signaling registers, link event counters, event and mask registers
// Overview of operation
// - Transmit-side writes while signaling: dropped, flagged
// - Reset clears transmit vector and length
// - One sends Halt, zero sends Master
// - Bits go out from bit 0 upward
// - Writing transmit vector starts signaling
// - Length upper bits ignored, read zero
// - Length field is bit count minus one
// - Received bit n captured into position n
// - Violation counter 8 bits, wraps, read-clear
// - Violation event per increment or overflow
// - Violation symbols from decoder increment counter
// - Idle monitor read-clear, upper bits zero
// - Track minimum idle pairs, event on drop
// - Minimum idle pairs use coded field
// - Occurrence count saturates at sixteen, event select
// - Occurrence count uses coded sequence
// - Link error counter 8 bits, wraps, read-clear
// - Link event when count equals limit
// - Limit register low byte, reset clear
// - Mask gates each event onto interrupt
// - Event register read-clear, reset clear
// - Event bits 15, 13, 12, 11
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module pbslc_core
    import pbslc_pkg::*;
#(
    parameter int ADDR_W = 5
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire pbslc_bus_t bus_req,
    output logic [15:0] rdata,
    input wire pbslc_line_t line_in,
    output logic tx_ls_halt,
    output logic tx_ls_master,
    output logic sig_active,
    output logic irq
);
    // The map is decoded on five index bits
    if (ADDR_W != 5) begin : g_chk
        $error("pbslc_core: ADDR_W must be 5");
    end

    pbslc_state_t s_r;
    pbslc_state_t s_nxt;

    logic wr_tx;
    logic wr_len;
    logic rd_bad;
    logic rd_idle;
    logic rd_lec;
    logic rd_evt;
    logic busy;
    logic bad_wrap;
    logic [7:0] bad_inc;
    logic [7:0] lec_inc;
    logic [15:0] new_ev;
    logic [15:0] rd_mux;

    // Access decode
    assign busy = (s_r.st == PBSLC_SIG_SEND);
    assign wr_tx = bus_req.wr && bus_req.addr == PBSLC_OFS_TX;
    assign wr_len = bus_req.wr && bus_req.addr == PBSLC_OFS_LEN;
    assign rd_bad = bus_req.rd && bus_req.addr == PBSLC_OFS_BAD;
    assign rd_idle = bus_req.rd && bus_req.addr == PBSLC_OFS_IDLE;
    assign rd_lec = bus_req.rd && bus_req.addr == PBSLC_OFS_LEC;
    assign rd_evt = bus_req.rd && bus_req.addr == PBSLC_OFS_EVT;
    assign bad_inc = s_r.bad + 8'h01;
    assign lec_inc = s_r.lec + 8'h01;
    assign bad_wrap = (s_r.bad == 8'hFF);

    // Read data mux; unmapped indices read zero
    always_comb begin
        case (bus_req.addr)
            PBSLC_OFS_TX: rd_mux = s_r.tx;
            PBSLC_OFS_LEN: rd_mux = {12'h000, s_r.len};
            PBSLC_OFS_LIM: rd_mux = {8'h00, s_r.lim};
            PBSLC_OFS_RX: rd_mux = s_r.rx;
            PBSLC_OFS_EVT: rd_mux = s_r.ev;
            PBSLC_OFS_BAD: rd_mux = {8'h00, s_r.bad};
            PBSLC_OFS_IDLE: rd_mux = {9'h000, PBSLC_MIN_CODE[s_r.imin],
                                      PBSLC_OCC_CODE[s_r.iocc]};
            PBSLC_OFS_LEC: rd_mux = {8'h00, s_r.lec};
            PBSLC_OFS_MASK: rd_mux = s_r.mask;
            PBSLC_OFS_CTLA: rd_mux = {14'h0000, s_r.ctl};
            default: rd_mux = PBSLC_RST_16;
        endcase
    end

    // Next state: one pass over every function of the block
    always_comb begin
        s_nxt = s_r;
        new_ev = PBSLC_RST_16;
        // Read data stands for the one cycle after the strobe
        s_nxt.rdata = bus_req.rd ? rd_mux : PBSLC_RST_16;

        // Transmit vector and length, locked while signaling
        if (wr_tx || wr_len) begin
            if (busy) begin
                new_ev[PBSLC_EV_INVALID] = 1'b1;
            end else if (wr_tx) begin
                s_nxt.tx = bus_req.wdata;
                s_nxt.st = PBSLC_SIG_SEND;
                s_nxt.idx = 4'h0;
                s_nxt.rx = PBSLC_RST_16;
            end else begin
                s_nxt.len = bus_req.wdata[3:0];
            end
        end
        // Writes to read-only registers are also invalid accesses
        if (bus_req.wr && (bus_req.addr == PBSLC_OFS_RX || bus_req.addr == PBSLC_OFS_EVT
                || bus_req.addr == PBSLC_OFS_BAD || bus_req.addr == PBSLC_OFS_IDLE
                || bus_req.addr == PBSLC_OFS_LEC)) begin
            new_ev[PBSLC_EV_INVALID] = 1'b1;
        end
        if (bus_req.wr && bus_req.addr == PBSLC_OFS_LIM) begin
            s_nxt.lim = bus_req.wdata[7:0];
        end
        if (bus_req.wr && bus_req.addr == PBSLC_OFS_MASK) begin
            s_nxt.mask = bus_req.wdata;
        end
        if (bus_req.wr && bus_req.addr == PBSLC_OFS_CTLA) begin
            s_nxt.ctl = bus_req.wdata[1:0];
        end

        // Bit signaling: one bit per tick from the bit timer
        case (s_r.st)
            PBSLC_SIG_IDLE: begin
            end
            PBSLC_SIG_SEND: begin
                if (line_in.bit_tick) begin
                    s_nxt.rx[s_r.idx] = line_in.rx_halt;
                    if (s_r.idx == s_r.len) begin
                        s_nxt.st = PBSLC_SIG_IDLE;
                    end else begin
                        s_nxt.idx = s_r.idx + 4'h1;
                    end
                end
            end
            default: s_nxt.st = PBSLC_SIG_IDLE;
        endcase
        // Line state request follows the current bit
        s_nxt.tx_halt = (s_nxt.st == PBSLC_SIG_SEND) && s_nxt.tx[s_nxt.idx];
        s_nxt.tx_master = (s_nxt.st == PBSLC_SIG_SEND) && !s_nxt.tx[s_nxt.idx];

        // Violation counter; a count arriving with the read is kept
        if (rd_bad) begin
            s_nxt.bad = line_in.viol ? 8'h01 : 8'h00;
        end else if (line_in.viol) begin
            s_nxt.bad = bad_inc;
        end
        if (line_in.viol && (!s_r.ctl[PBSLC_CTL_BAD_SEL] || (bad_wrap && !rd_bad))) begin
            new_ev[PBSLC_EV_BAD] = 1'b1;
        end

        // Idle gap monitor: minimum and how often it was seen
        if (rd_idle) begin
            s_nxt.imin = PBSLC_IDLE_MIN_RST;
            s_nxt.iocc = PBSLC_OCC_RST;
        end
        if (line_in.gap_seen) begin
            if (line_in.gap_pairs < s_nxt.imin) begin
                s_nxt.imin = line_in.gap_pairs;
                s_nxt.iocc = PBSLC_OCC_RST;
                new_ev[PBSLC_EV_IDLE] = 1'b1;
            end else if (line_in.gap_pairs == s_nxt.imin && s_nxt.iocc != PBSLC_OCC_MAX) begin
                s_nxt.iocc = s_nxt.iocc + 4'h1;
                if (!s_r.ctl[PBSLC_CTL_IDLE_SEL] || s_nxt.iocc == PBSLC_OCC_MAX) begin
                    new_ev[PBSLC_EV_IDLE] = 1'b1;
                end
            end
        end

        // Link error counter and threshold compare on the new value
        if (rd_lec) begin
            s_nxt.lec = line_in.link_err ? 8'h01 : 8'h00;
        end else if (line_in.link_err) begin
            s_nxt.lec = lec_inc;
        end
        if (line_in.link_err && s_nxt.lec == s_r.lim) begin
            new_ev[PBSLC_EV_LINK] = 1'b1;
        end

        // Events: read clears, a new event in the same cycle survives
        s_nxt.ev = (rd_evt ? PBSLC_RST_16 : s_r.ev) | new_ev;
        // Interrupt taken from the next event and mask values
        s_nxt.irq = |(s_nxt.ev & s_nxt.mask);
    end

    // State register; reset clears all but the signaling state, which goes idle, and the idle minimum, which restarts at seven
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.st <= PBSLC_SIG_IDLE;
            s_r.imin <= PBSLC_IDLE_MIN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign tx_ls_halt = s_r.tx_halt;
    assign tx_ls_master = s_r.tx_master;
    assign sig_active = s_r.st[1]; // One-hot send bit, no decode after the flop
    assign irq = s_r.irq;

    // Checks beside the logic
    property p_busy_drop;
        @(posedge sys_clk) disable iff (!rst_b)
        (bus_req.wr && bus_req.addr == PBSLC_OFS_TX && busy)
            |=> $stable(s_r.tx) && s_r.ev[PBSLC_EV_INVALID];
    endproperty
    a_busy_drop: assert property (p_busy_drop) else $error("busy write not dropped");

    property p_start;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr_tx && !busy) |=> sig_active && s_r.idx == 4'h0 && s_r.tx == $past(bus_req.wdata);
    endproperty
    a_start: assert property (p_start) else $error("write did not start signaling");

    property p_line_map;
        @(posedge sys_clk) disable iff (!rst_b)
        busy |-> tx_ls_halt == s_r.tx[s_r.idx] && tx_ls_master == !s_r.tx[s_r.idx];
    endproperty
    a_line_map: assert property (p_line_map) else $error("line state mismatch");

    property p_capture;
        @(posedge sys_clk) disable iff (!rst_b)
        (busy && line_in.bit_tick) |=> s_r.rx[$past(s_r.idx)] == $past(line_in.rx_halt);
    endproperty
    a_capture: assert property (p_capture) else $error("receive bit not captured");

    property p_end;
        @(posedge sys_clk) disable iff (!rst_b)
        (busy && line_in.bit_tick && s_r.idx == s_r.len) |=> !sig_active ##1 !tx_ls_halt;
    endproperty
    a_end: assert property (p_end) else $error("signaling did not end");

    property p_len_read;
        @(posedge sys_clk) disable iff (!rst_b)
        (bus_req.rd && bus_req.addr == PBSLC_OFS_LEN) |=> rdata[15:4] == 12'h000;
    endproperty
    a_len_read: assert property (p_len_read) else $error("length upper bits set");

    property p_bad_count;
        @(posedge sys_clk) disable iff (!rst_b)
        (line_in.viol && !rd_bad) |=> s_r.bad == 8'($past(s_r.bad) + 8'h01);
    endproperty
    a_bad_count: assert property (p_bad_count) else $error("violation count wrong");

    property p_link_hit;
        @(posedge sys_clk) disable iff (!rst_b)
        (line_in.link_err && !rd_lec && lec_inc == s_r.lim) |=> s_r.ev[PBSLC_EV_LINK];
    endproperty
    a_link_hit: assert property (p_link_hit) else $error("link event missed");

    property p_min_drop;
        @(posedge sys_clk) disable iff (!rst_b)
        (line_in.gap_seen && !rd_idle && line_in.gap_pairs < s_r.imin)
            |=> s_r.imin == $past(line_in.gap_pairs) && s_r.ev[PBSLC_EV_IDLE];
    endproperty
    a_min_drop: assert property (p_min_drop) else $error("idle minimum not tracked");

    property p_evt_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        (rd_evt && new_ev == PBSLC_RST_16) |=> s_r.ev == PBSLC_RST_16 && !irq;
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("event register not cleared");

    property p_irq;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(irq) |-> (s_r.ev & s_r.mask) != PBSLC_RST_16;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without masked event");

    property p_len_drop;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr_len && busy) |=> $stable(s_r.len) && s_r.ev[PBSLC_EV_INVALID];
    endproperty
    a_len_drop: assert property (p_len_drop) else $error("length write not dropped");

    property p_idx_step;
        @(posedge sys_clk) disable iff (!rst_b)
        (busy && line_in.bit_tick && s_r.idx != s_r.len)
            |=> sig_active && s_r.idx == 4'($past(s_r.idx) + 4'h1);
    endproperty
    a_idx_step: assert property (p_idx_step) else $error("bit index did not advance");

    property p_idx_bound;
        @(posedge sys_clk) disable iff (!rst_b)
        busy |-> s_r.idx <= s_r.len;
    endproperty
    a_idx_bound: assert property (p_idx_bound) else $error("bit index past length");

    property p_bad_quiet;
        @(posedge sys_clk) disable iff (!rst_b)
        (line_in.viol && s_r.ctl[PBSLC_CTL_BAD_SEL] && !bad_wrap)
            |=> !s_r.ev[PBSLC_EV_BAD] || $past(s_r.ev[PBSLC_EV_BAD]);
    endproperty
    a_bad_quiet: assert property (p_bad_quiet) else $error("violation event before wrap");

    property p_bad_every;
        @(posedge sys_clk) disable iff (!rst_b)
        (line_in.viol && !s_r.ctl[PBSLC_CTL_BAD_SEL]) |=> s_r.ev[PBSLC_EV_BAD];
    endproperty
    a_bad_every: assert property (p_bad_every) else $error("violation event missed");

    property p_bad_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        (rd_bad && !line_in.viol) |=> s_r.bad == 8'h00;
    endproperty
    a_bad_clear: assert property (p_bad_clear) else $error("violation count not cleared");

    property p_idle_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        (rd_idle && !line_in.gap_seen)
            |=> s_r.imin == PBSLC_IDLE_MIN_RST && s_r.iocc == PBSLC_OCC_RST;
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("idle monitor not cleared");

    property p_occ_sat;
        @(posedge sys_clk) disable iff (!rst_b)
        (line_in.gap_seen && !rd_idle && line_in.gap_pairs == s_r.imin
            && s_r.iocc == PBSLC_OCC_MAX)
            |=> s_r.iocc == PBSLC_OCC_MAX;
    endproperty
    a_occ_sat: assert property (p_occ_sat) else $error("occurrence count left sixteen");

    property p_occ_step;
        @(posedge sys_clk) disable iff (!rst_b)
        (line_in.gap_seen && !rd_idle && line_in.gap_pairs == s_r.imin
            && s_r.iocc != PBSLC_OCC_MAX)
            |=> s_r.iocc == 4'($past(s_r.iocc) + 4'h1);
    endproperty
    a_occ_step: assert property (p_occ_step) else $error("occurrence count wrong");

    property p_lec_count;
        @(posedge sys_clk) disable iff (!rst_b)
        (line_in.link_err && !rd_lec) |=> s_r.lec == 8'($past(s_r.lec) + 8'h01);
    endproperty
    a_lec_count: assert property (p_lec_count) else $error("link error count wrong");

    property p_lim_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (bus_req.wr && bus_req.addr == PBSLC_OFS_LIM)
            |=> s_r.lim == $past(bus_req.wdata[7:0]);
    endproperty
    a_lim_write: assert property (p_lim_write) else $error("limit not written");

    property p_evt_keep;
        @(posedge sys_clk) disable iff (!rst_b)
        !rd_evt |=> (s_r.ev & $past(s_r.ev)) == $past(s_r.ev);
    endproperty
    a_evt_keep: assert property (p_evt_keep) else $error("event lost without read");

    property p_ls_idle;
        @(posedge sys_clk) disable iff (!rst_b)
        !busy |-> !tx_ls_halt && !tx_ls_master;
    endproperty
    a_ls_idle: assert property (p_ls_idle) else $error("line state while idle");
endmodule : pbslc_core

// >>> tb/pbslc_peer.sv
// Neighbour connection manager model: answers each signaling bit
`timescale 1ns/1ps
module pbslc_peer (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic sig_active,
    input wire logic tx_ls_halt,
    input wire logic tx_ls_master,
    input wire logic slow,
    input wire logic [15:0] reply,
    output logic bit_tick,
    output logic rx_halt,
    output logic [15:0] seen,
    output logic [4:0] nbits,
    output logic bad_ls
);
    logic [2:0] wait_r;
    logic act_d;
    // One tick per bit; slow mode stalls each bit four cycles
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            {bit_tick, rx_halt, seen, nbits, bad_ls, wait_r, act_d} <= '0;
        end else begin
            act_d <= sig_active;
            if (sig_active && !act_d) begin
                {seen, nbits, wait_r} <= '0;
            end else if (sig_active && !bit_tick) begin
                if (wait_r >= (slow ? 3'h4 : 3'h0)) begin
                    bit_tick <= 1'b1;
                    rx_halt <= reply[nbits[3:0]];
                    seen[nbits[3:0]] <= tx_ls_halt;
                    bad_ls <= bad_ls | (tx_ls_halt == tx_ls_master);
                    nbits <= nbits + 5'h01;
                    wait_r <= '0;
                end else begin
                    wait_r <= wait_r + 3'h1;
                end
            end else begin
                bit_tick <= 1'b0;
                // Line released: never leave a stale level
                if (!sig_active) rx_halt <= ~rx_halt;
            end
        end
    end
endmodule : pbslc_peer

// >>> tb/tb_top.sv
// Self-checking bench for the signaling registers and link counters
`timescale 1ns/1ps
module tb_top
    import pbslc_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    pbslc_bus_t bus_req = '0;
    logic [15:0] rdata, seen, tx, mask;
    logic [15:0] reply = '0;
    logic tick, rxh, halt, mast, act, irq, bad_ls;
    logic slow = 1'b0;
    logic rd_p = 1'b0;
    logic [2:0] pul = '0;
    logic [2:0] pairs = '0;
    logic [4:0] nbits;
    logic [15:0] exp_q[$];
    int miscompares = 0;
    int n_tests = 0;
    int seed = 32'hf519;
    int k;
    pbslc_line_t line;
    logic [2:0] minc [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h5, 3'h4};
    logic [3:0] occc [16] = '{4'h0, 4'h8, 4'hC, 4'h4, 4'h5, 4'h7, 4'hF, 4'hE,
                              4'hA, 4'h2, 4'h3, 4'h1, 4'h9, 4'hD, 4'h6, 4'hB};
    // Pulses: [2] violation, [1] gap, [0] link error
    assign line = '{tick, rxh, pul[2], pul[1], pairs, pul[0]};
    always #50 sys_clk = ~sys_clk;
    pbslc_core dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .bus_req(bus_req), .rdata(rdata),
        .line_in(line), .tx_ls_halt(halt), .tx_ls_master(mast), .sig_active(act), .irq(irq));
    pbslc_peer peer_u (.sys_clk(sys_clk), .rst_b(rst_b), .sig_active(act), .tx_ls_halt(halt),
        .tx_ls_master(mast), .slow(slow), .reply(reply), .bit_tick(tick), .rx_halt(rxh),
        .seen(seen), .nbits(nbits), .bad_ls(bad_ls));
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        n_tests++;
        if (got !== want) begin
            miscompares++;
            $display("[FAIL] %0t ns: got %h, expected %h", $time, got, want);
        end
    endtask : check
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
    endtask : wr
    // Expected read data is noted now and compared when it appears
    task automatic rd(input logic [4:0] a, input logic [15:0] want);
        @(posedge sys_clk);
        bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
        exp_q.push_back(want);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            bus_req <= '0;
        end
    endtask : cyc
    task automatic pulse(input int which, input int n, input logic [2:0] p);
        repeat (n) begin
            @(posedge sys_clk);
            bus_req <= '0;
            pul <= 3'(1 << which);
            pairs <= p;
            @(posedge sys_clk);
            pul <= '0;
        end
    endtask : pulse
    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (rd_p) check(rdata, exp_q.pop_front());
        rd_p <= bus_req.rd;
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(PBSLC_OFS_TX, 16'h0000);
        rd(PBSLC_OFS_LEN, 16'h0000);
        rd(PBSLC_OFS_LIM, 16'h0000);
        rd(PBSLC_OFS_EVT, 16'h0000);
        rd(PBSLC_OFS_IDLE, 16'h0040);
        rd(PBSLC_OFS_LEC, 16'h0000);
        rd(5'h1F, 16'h0000);
        wr(PBSLC_OFS_BAD, 16'h00FF);
        wr(PBSLC_OFS_LIM, 16'hFFAB);
        wr(PBSLC_OFS_LEN, 16'hFFF3);
        rd(PBSLC_OFS_LIM, 16'h00AB);
        rd(PBSLC_OFS_LEN, 16'h0003);
        rd(PBSLC_OFS_EVT, 16'h8000);
        rd(PBSLC_OFS_BAD, 16'h0000);
        // Signaling runs: shortest, longest and random lengths
        for (int i = 0; i < 4; i++) begin
            k = (i == 0) ? 0 : (i == 3) ? 15 : ($unsigned($random(seed)) % 15);
            tx = 16'($random(seed));
            reply <= 16'($random(seed));
            slow <= i[0];
            mask = 16'hFFFF >> (15 - k);
            wr(PBSLC_OFS_LEN, 16'(k));
            wr(PBSLC_OFS_TX, tx);
            wr(PBSLC_OFS_TX, ~tx);
            wr(PBSLC_OFS_LEN, 16'h0007);
            rd(PBSLC_OFS_EVT, 16'h8000);
            for (int w = 0; act === 1'b1; w++) begin
                if (w > 200) begin
                    miscompares++;
                    report_and_stop();
                end
                cyc(1);
            end
            cyc(2);
            check({11'h000, nbits}, 16'(k + 1));
            check(seen & mask, tx & mask);
            check(16'(bad_ls), 16'h0000);
            rd(PBSLC_OFS_RX, reply & mask);
            rd(PBSLC_OFS_TX, tx);
            rd(PBSLC_OFS_LEN, 16'(k));
        end
        // Reset after the last run has ended must clear a written vector and length
        cyc(2);
        rst_b <= 1'b0;
        cyc(2);
        rst_b <= 1'b1;
        rd(PBSLC_OFS_TX, 16'h0000);
        rd(PBSLC_OFS_LEN, 16'h0000);
        // Violation counter, per-increment then overflow events
        wr(PBSLC_OFS_MASK, 16'h0800);
        k = 1 + ($unsigned($random(seed)) % 20);
        pulse(2, k, 3'h0);
        cyc(3);
        check(16'(irq), 16'h0001);
        rd(PBSLC_OFS_BAD, 16'(k));
        rd(PBSLC_OFS_EVT, 16'h0800);
        rd(PBSLC_OFS_BAD, 16'h0000);
        wr(PBSLC_OFS_MASK, 16'h0000);
        pulse(2, 1, 3'h0);
        cyc(3);
        check(16'(irq), 16'h0000);
        rd(PBSLC_OFS_EVT, 16'h0800);
        rd(PBSLC_OFS_BAD, 16'h0001);
        wr(PBSLC_OFS_CTLA, 16'h0001);
        pulse(2, 255, 3'h0);
        rd(PBSLC_OFS_EVT, 16'h0000);
        pulse(2, 1, 3'h0);
        rd(PBSLC_OFS_BAD, 16'h0000);
        rd(PBSLC_OFS_EVT, 16'h0800);
        // Link error count against the limit, then wrap
        wr(PBSLC_OFS_LIM, 16'h0003);
        pulse(0, 2, 3'h0);
        rd(PBSLC_OFS_EVT, 16'h0000);
        pulse(0, 1, 3'h0);
        rd(PBSLC_OFS_EVT, 16'h2000);
        rd(PBSLC_OFS_LEC, 16'h0003);
        pulse(0, 256, 3'h0);
        rd(PBSLC_OFS_LEC, 16'h0000);
        rd(PBSLC_OFS_EVT, 16'h2000);
        // Idle minimum: codes for zero to six, then occurrence counts
        wr(PBSLC_OFS_CTLA, 16'h0000);
        for (int p = 0; p < 7; p++) begin
            pulse(1, 1, p[2:0]);
            rd(PBSLC_OFS_EVT, 16'h1000);
            rd(PBSLC_OFS_IDLE, {9'h000, minc[p], 4'h0});
        end
        k = 2 + ($unsigned($random(seed)) % 14);
        pulse(1, k, 3'h3);
        rd(PBSLC_OFS_EVT, 16'h1000);
        rd(PBSLC_OFS_IDLE, {9'h000, minc[3], occc[k - 1]});
        wr(PBSLC_OFS_CTLA, 16'h0002);
        pulse(1, 1, 3'h2);
        rd(PBSLC_OFS_EVT, 16'h1000);
        pulse(1, 14, 3'h2);
        rd(PBSLC_OFS_EVT, 16'h0000);
        pulse(1, 1, 3'h2);
        rd(PBSLC_OFS_EVT, 16'h1000);
        pulse(1, 1, 3'h2);
        rd(PBSLC_OFS_EVT, 16'h0000);
        rd(PBSLC_OFS_IDLE, {9'h000, minc[2], occc[15]});
        cyc(4);
        report_and_stop();
    end
endmodule : tb_top
